// ### rtl/pss_defines.vh
// Field positions, widths and reset values of the synthesizer core.
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

`define PSS_SHIFT_W        18
`define PSS_WORD_W         17
`define PSS_SEL_BIT        0
`define PSS_SEL_REFERENCE  1'h1
`define PSS_SEL_FEEDBACK   1'h0

`define PSS_REF_VAL_MSB    9
`define PSS_REF_VAL_LSB    0
`define PSS_PUMP_FLOAT_BIT 10
`define PSS_POLARITY_BIT   11
`define PSS_RESERVED_BIT   12
`define PSS_TEST_BIT       13

`define PSS_MAIN_MSB       16
`define PSS_MAIN_LSB       7
`define PSS_SWALLOW_MSB    6
`define PSS_SWALLOW_LSB    2
`define PSS_CTRL_MSB       1
`define PSS_CTRL_LSB       0
`define PSS_SLEEP_BIT      1

`define PSS_REF_WORD_RST   17'h00402
`define PSS_FB_WORD_RST    17'h00000

`define PSS_PRESCALE_LOW   6'h20
`define PSS_PRESCALE_HIGH  6'h21

`endif

// ### rtl/pss_core.v
// Digital core of an integer-N synthesizer with its serial programming port.
`timescale 1ns/100ps
`default_nettype none
`include "pss_defines.vh"

// Functional notes
// - Reference divider, 10 bits, ratio 2 to 1023.
// - Reference divider clocked from reference input.
// - Feedback divider: 5-bit swallow, 10-bit main.
// - Dual-modulus 32/33 prescaler clocks counter chain.
// - Detector compares both dividers, drives pump.
// - Polarity bit picks pump direction for lag.
// - Pump drives high, low, or floats.
// - Test mode with float bit set presents divider output on pump.
// - Serial bits MSB first on clock rise.
// - Last bit one selects reference, zero feedback.
// - Strobe rise copies data to selected latch.
// - Data field bits 17..1, select bit 0.
// - Feedback word: main, swallow, control pair.
// - Chip enable low floats pump immediately.
// - Sleep bit stops dividers, unbiases inputs.
// - Any power-down floats pump and detector.
// - Power-down resets counters, restart aligned together.
// - Serial loading works in every power-down.
// - Reference word: value, float, polarity, reserved, test.
// - Float bit set forces pump to float unless test bit also set.
// - Test mode: polarity selects reference or feedback.
module pss_core (
  input  wire core_clk_in,
  input  wire rst_in,
  input  wire serial_clk_in,
  input  wire serial_data_in,
  input  wire latch_strobe_in,
  input  wire chip_enable_in,
  input  wire reference_input_in,
  input  wire rf_input_in,
  output wire pump_output_out,
  output wire pump_output_oe_out,
  output wire reference_input_bias_out,
  output wire rf_input_bias_out
);

  // Returns the next value of a divide-by-lim counter; zero at terminal.
  // A limit of zero or one is not trapped: one wraps on every edge and zero
  // runs through all 1024 states, so the host must keep to the legal ranges.
  function [9:0] pss_next_count;
    input [9:0] cnt;
    input [9:0] lim;
    begin
      if (cnt >= lim - 10'h001) begin
        pss_next_count = 10'h000;
      end else begin
        pss_next_count = cnt + 10'h001;
      end
    end
  endfunction

  // Two-stage synchronisers for every pin input, plus a third stage for edges.
  // Every pin is sampled by the core clock, so each level of the reference and
  // rf inputs must last more than one core clock or edges are lost. This trades
  // input frequency range for a design with a single clock domain.
  reg  [5:0]  sync1_ff;
  reg  [5:0]  sync2_ff;
  reg  [5:0]  sync3_ff;
  wire        sclk_rise;
  wire        strobe_rise;
  wire        ref_rise;
  wire        rf_rise;
  wire        sdata_s;
  wire        ce_s;

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      sync3_ff <= 6'h00;
    end else begin
      sync1_ff <= {rf_input_in, reference_input_in, chip_enable_in,
                   latch_strobe_in, serial_data_in, serial_clk_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign sclk_rise   = sync2_ff[0] & ~sync3_ff[0];
  // Data is taken one stage late so it still shows the value set up before the edge.
  assign sdata_s     = sync3_ff[1];
  assign strobe_rise = sync2_ff[2] & ~sync3_ff[2];
  assign ce_s        = sync2_ff[3];
  assign ref_rise    = sync2_ff[4] & ~sync3_ff[4];
  assign rf_rise     = sync2_ff[5] & ~sync3_ff[5];

  // Serial shift register and the two latches; never gated by power-down.
  // Bits enter at the bottom, so the first bit sent ends in the top place.
  // A strobe seen in the same cycle as a clock rise latches the word as it
  // stood before that bit, so the host must keep the two apart.
  reg  [17:0] shift_ff;
  reg  [16:0] reference_divider_word_ff;
  reg  [16:0] feedback_divider_word_ff;

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      shift_ff                  <= 18'h00000;
      reference_divider_word_ff <= `PSS_REF_WORD_RST;
      feedback_divider_word_ff  <= `PSS_FB_WORD_RST;
    end else begin
      if (sclk_rise) begin
        shift_ff <= {shift_ff[16:0], sdata_s};
      end
      if (strobe_rise) begin
        if (shift_ff[`PSS_SEL_BIT] == `PSS_SEL_REFERENCE) begin
          reference_divider_word_ff <= shift_ff[17:1];
        end else begin
          feedback_divider_word_ff <= shift_ff[17:1];
        end
      end
    end
  end

  // Decoded latch fields.
  // The reserved bit and the low control bit are stored but have no effect.
  wire [9:0]  reference_divide_value;
  wire        pump_float;
  wire        detector_polarity;
  wire        test_mode;
  wire [9:0]  main_count;
  wire [4:0]  swallow_count;
  wire [1:0]  control_pair;
  wire        sleep_bit;

  assign reference_divide_value =
    reference_divider_word_ff[`PSS_REF_VAL_MSB:`PSS_REF_VAL_LSB];
  assign pump_float        = reference_divider_word_ff[`PSS_PUMP_FLOAT_BIT];
  assign detector_polarity = reference_divider_word_ff[`PSS_POLARITY_BIT];
  assign test_mode         = reference_divider_word_ff[`PSS_TEST_BIT];
  assign main_count    = feedback_divider_word_ff[`PSS_MAIN_MSB:`PSS_MAIN_LSB];
  assign swallow_count = feedback_divider_word_ff[`PSS_SWALLOW_MSB:`PSS_SWALLOW_LSB];
  assign control_pair  = feedback_divider_word_ff[`PSS_CTRL_MSB:`PSS_CTRL_LSB];
  // The sleep bit is the upper bit of the control pair.
  assign sleep_bit     = control_pair[`PSS_SLEEP_BIT];

  // Synchronised power-down: either the pin or the sleep bit.
  // The raw pin also gates the outputs at the end of this module, so that the
  // float on a low chip enable does not wait for the synchroniser.
  wire power_down;
  assign power_down = ~ce_s | sleep_bit;

  // Reference divider, advanced by each sampled reference edge.
  // The terminal pulse lasts one core clock and comes once per programmed
  // number of reference edges.
  reg  [9:0]  ref_cnt_ff;
  reg         ref_tc_ff;

  always @(posedge core_clk_in) begin
    if (rst_in || power_down) begin
      ref_cnt_ff <= 10'h000;
      ref_tc_ff  <= 1'b0;
    end else if (ref_rise) begin
      ref_cnt_ff <= pss_next_count(ref_cnt_ff, reference_divide_value);
      ref_tc_ff  <= (pss_next_count(ref_cnt_ff, reference_divide_value) == 10'h000);
    end else begin
      ref_tc_ff  <= 1'b0;
    end
  end

  // Dual-modulus prescaler, 33 while the swallow counter is still running.
  // The swallow counter stops at the swallow count, so the first prescaler
  // cycles of each main period divide by 33 and the rest by 32. It restarts
  // with the main counter so that every feedback period begins alike.
  reg  [5:0]  pre_cnt_ff;
  reg  [4:0]  sw_cnt_ff;
  reg  [9:0]  main_cnt_ff;
  reg         fb_tc_ff;
  wire        swallow_active;
  wire [5:0]  modulus;
  wire        pre_tc;

  assign swallow_active = (sw_cnt_ff < swallow_count);
  assign modulus        = swallow_active ? `PSS_PRESCALE_HIGH : `PSS_PRESCALE_LOW;
  assign pre_tc         = rf_rise && (pre_cnt_ff == modulus - 6'h01);

  always @(posedge core_clk_in) begin
    if (rst_in || power_down) begin
      pre_cnt_ff  <= 6'h00;
      sw_cnt_ff   <= 5'h00;
      main_cnt_ff <= 10'h000;
      fb_tc_ff    <= 1'b0;
    end else begin
      fb_tc_ff <= 1'b0;
      if (rf_rise) begin
        pre_cnt_ff <= pre_tc ? 6'h00 : pre_cnt_ff + 6'h01;
      end
      if (pre_tc) begin
        main_cnt_ff <= pss_next_count(main_cnt_ff, main_count);
        if (pss_next_count(main_cnt_ff, main_count) == 10'h000) begin
          sw_cnt_ff <= 5'h00;
          fb_tc_ff  <= 1'b1;
        end else if (swallow_active) begin
          sw_cnt_ff <= sw_cnt_ff + 5'h01;
        end
      end
    end
  end

  // Phase/frequency detector: first pulse sets its flag, the second clears both.
  // A pulse that arrives in the clearing cycle counts as the matching edge.
  // The float bit idles the detector as well, so no stale flag can drive the
  // pump in the first cycle after the float bit is cleared.
  // Test mode reads the divider halves, not these flags, so it is unaffected.
  reg         ref_lead_ff;
  reg         fb_lead_ff;

  always @(posedge core_clk_in) begin
    if (rst_in || power_down || pump_float) begin
      ref_lead_ff <= 1'b0;
      fb_lead_ff  <= 1'b0;
    end else begin
      if ((ref_tc_ff | ref_lead_ff) & (fb_tc_ff | fb_lead_ff)) begin
        ref_lead_ff <= 1'b0;
        fb_lead_ff  <= 1'b0;
      end else begin
        ref_lead_ff <= ref_lead_ff | ref_tc_ff;
        fb_lead_ff  <= fb_lead_ff | fb_tc_ff;
      end
    end
  end

  // Divider halves for test observation; a square wave survives the pin better than pulses.
  reg         ref_half_ff;
  reg         fb_half_ff;

  always @(posedge core_clk_in) begin
    if (rst_in || power_down) begin
      ref_half_ff <= 1'b0;
      fb_half_ff  <= 1'b0;
    end else begin
      ref_half_ff <= ref_half_ff ^ ref_tc_ff;
      fb_half_ff  <= fb_half_ff ^ fb_tc_ff;
    end
  end

  // Pump level and enable.
  // Both are registered so that the pin never glitches while the flags and
  // the float bit settle within one cycle.
  wire pump_up;
  wire pump_dn;
  wire test_active;
  reg  nxt_pump_level;
  reg  nxt_pump_oe;
  reg  pump_level_ff;
  reg  pump_oe_ff;
  reg  bias_on_ff;

  // A lagging feedback means the reference flag is up.
  assign pump_up     = detector_polarity ? ref_lead_ff : fb_lead_ff;
  assign pump_dn     = detector_polarity ? fb_lead_ff : ref_lead_ff;
  // Test output is only honoured with the float bit also set.
  // Without the float bit the test bit is ignored and the pump runs normally.
  assign test_active = test_mode & pump_float;

  always @* begin
    nxt_pump_level = 1'b0;
    nxt_pump_oe    = 1'b0;
    // Power-down outranks test mode, and test mode outranks the float bit.
    if (power_down) begin
      nxt_pump_oe = 1'b0;
    end else if (test_active) begin
      nxt_pump_oe    = 1'b1;
      nxt_pump_level = detector_polarity ? fb_half_ff : ref_half_ff;
    end else if (pump_float) begin
      nxt_pump_oe = 1'b0;
    end else if (pump_up != pump_dn) begin
      nxt_pump_oe    = 1'b1;
      nxt_pump_level = pump_up;
    end
  end

  // The bias outputs follow the power state one clock late, which keeps them
  // in step with the pump enable register.
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      pump_level_ff <= 1'b0;
      pump_oe_ff    <= 1'b0;
      bias_on_ff    <= 1'b0;
    end else begin
      pump_level_ff <= nxt_pump_level;
      pump_oe_ff    <= nxt_pump_oe;
      bias_on_ff    <= ~power_down;
    end
  end

  // The raw pin gates the drivers so that a low chip enable acts without a clock.
  // The level is gated too, so that a floating pin never shows a stale high.
  assign pump_output_out          = pump_level_ff & chip_enable_in;
  assign pump_output_oe_out       = pump_oe_ff & chip_enable_in;
  assign reference_input_bias_out = bias_on_ff & chip_enable_in;
  assign rf_input_bias_out        = bias_on_ff & chip_enable_in;

endmodule // pss_core

`default_nettype wire

// ### dv/pss_core_assertions.sv
// Pin-level assertions for the synthesizer core.
`timescale 1ns/100ps
`default_nettype none
module pss_core_assertions (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic chip_enable_in,
  input wire logic pump_output_out,
  input wire logic pump_output_oe_out,
  input wire logic reference_input_bias_out,
  input wire logic rf_input_bias_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_ce_float: assert property (!chip_enable_in |-> !pump_output_oe_out)
    else $error("pump drives with enable low");
  a_ce_level: assert property (!chip_enable_in |-> !pump_output_out)
    else $error("pump level high with enable low");
  a_ce_refbias: assert property (!chip_enable_in |-> !reference_input_bias_out)
    else $error("reference bias on with enable low");
  a_ce_rfbias: assert property (!chip_enable_in |-> !rf_input_bias_out)
    else $error("rf bias on with enable low");
  a_bias_pair: assert property (reference_input_bias_out == rf_input_bias_out)
    else $error("input biases disagree");
  a_sleep_float: assert property (!rf_input_bias_out && !$past(rf_input_bias_out)
    |-> !pump_output_oe_out) else $error("pump drives in power down");
  a_float_default: assert property ($fell(rst_in) |-> !pump_output_oe_out [*8])
    else $error("pump drives after reset");
  a_bias_wake: assert property ($fell(rst_in) && chip_enable_in |-> ##3 rf_input_bias_out)
    else $error("no bias after reset");
  c_up: cover property (pump_output_oe_out && pump_output_out);
  c_down: cover property (pump_output_oe_out && !pump_output_out);
  c_sleep: cover property (chip_enable_in && $fell(rf_input_bias_out));
endmodule // pss_core_assertions
bind pss_core pss_core_assertions u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .chip_enable_in(chip_enable_in), .pump_output_out(pump_output_out),
  .pump_output_oe_out(pump_output_oe_out),
  .reference_input_bias_out(reference_input_bias_out),
  .rf_input_bias_out(rf_input_bias_out));
`default_nettype wire

// ### dv/pss_host_model.sv
// Host that shifts words into the serial port.
`timescale 1ns/100ps
`default_nettype none
module pss_host_model (
  input  wire logic        core_clk_in,
  input  wire logic        start_in,
  input  wire logic [17:0] word_in,
  output var  logic        serial_clk_out,
  output var  logic        serial_data_out,
  output var  logic        latch_strobe_out,
  output var  logic        busy_out
);
  task automatic hold;
    repeat (4) @(posedge core_clk_in);
    #1;
  endtask
  initial begin
    serial_clk_out = 1'h0;
    serial_data_out = 1'h0;
    latch_strobe_out = 1'h0;
    busy_out = 1'h0;
    forever begin
      @(posedge core_clk_in);
      if (start_in) begin
        busy_out = 1'h1;
        #1;
        for (int i = 17; i >= 0; i--) begin
          serial_data_out = word_in[i];
          hold();
          serial_clk_out = 1'h1;
          hold();
          serial_clk_out = 1'h0;
          hold();
        end
        // Flip the idle data so a stale last bit never looks valid.
        serial_data_out = ~serial_data_out;
        latch_strobe_out = 1'h1;
        hold();
        latch_strobe_out = 1'h0;
        repeat (4) @(posedge core_clk_in);
        busy_out = 1'h0;
      end
    end
  end
endmodule // pss_host_model
`default_nettype wire

// ### dv/tb_pss_core.sv
// Self-checking bench for the synthesizer core.
`timescale 1ns/100ps
`default_nettype none
module tb_pss_core;
  logic        clk  = 1'h0;
  logic        rst  = 1'h1;
  logic        ce   = 1'h1;
  logic        go   = 1'h0;
  logic [17:0] word = 18'h00000;
  logic [1:0]  osc  = 2'h0;
  logic [15:0] n;
  wire         sclk, sdat, stb, busy, pump, oe, rbias, fbias;
  int          n_mismatch = 0;
  int          compares   = 0;
  always #20 clk = ~clk;
  // Both divider inputs run at a quarter of the core rate, inside the sampling limit.
  always @(posedge clk) begin
    #1;
    osc = osc + 2'h1;
  end
  pss_host_model host (.core_clk_in(clk), .start_in(go), .word_in(word),
    .serial_clk_out(sclk), .serial_data_out(sdat), .latch_strobe_out(stb), .busy_out(busy));
  pss_core uut (.core_clk_in(clk), .rst_in(rst), .serial_clk_in(sclk), .serial_data_in(sdat),
    .latch_strobe_in(stb), .chip_enable_in(ce), .reference_input_in(osc[1]),
    .rf_input_in(osc[1]), .pump_output_out(pump), .pump_output_oe_out(oe),
    .reference_input_bias_out(rbias), .rf_input_bias_out(fbias));
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_cnt(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timeout;
    n_mismatch++;
    print_verdict();
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [17:0] w);
    word = w;
    go = 1'h1;
    for (int i = 0; i < 20 && busy !== 1'h1; i++) tick(1);
    go = 1'h0;
    if (busy !== 1'h1) timeout();
    for (int i = 0; i < 600 && busy === 1'h1; i++) tick(1);
    if (busy !== 1'h0) timeout();
  endtask
  function automatic logic [17:0] ref_w(logic t, logic p, logic f, logic [9:0] v);
    return {3'h0, t, 1'h0, p, f, v, 1'h1};
  endfunction
  function automatic logic [17:0] fb_w(logic [9:0] m, logic [4:0] a, logic s);
    return {m, a, s, 2'h0};
  endfunction
  // The first two edges after a change may be irregular, so the third gap is timed.
  task automatic period;
    logic last;
    for (int k = 0; k < 3; k++) begin
      last = pump;
      n = 16'h0000;
      while (pump === last && n < 16'h2000) begin
        tick(1);
        n++;
      end
    end
    if (n == 16'h2000) timeout();
  endtask
  task automatic t_reset;
    check_bit(oe, 1'h0);
    check_bit(fbias, 1'h1);
    $display("test reset done");
  endtask
  task automatic t_test;
    int v[3] = '{2, 5, 1023};
    int m[3] = '{3, 31, 31};
    int a[3] = '{2, 0, 31};
    for (int i = 0; i < 3; i++) begin
      send(ref_w(1'h1, 1'h0, 1'h1, 10'(v[i])));
      period();
      check_cnt(n, 16'(4 * v[i]));
    end
    send(ref_w(1'h1, 1'h1, 1'h1, 10'h002));
    for (int i = 0; i < 3; i++) begin
      send(fb_w(10'(m[i]), 5'(a[i]), 1'h0));
      period();
      check_cnt(n, 16'(4 * (32 * m[i] + a[i])));
    end
    $display("test divider ratios done");
  endtask
  task automatic t_sleep;
    send(fb_w(10'h003, 5'h02, 1'h1));
    check_bit(rbias, 1'h0);
    check_bit(oe, 1'h0);
    send(ref_w(1'h1, 1'h0, 1'h1, 10'h005));
    send(fb_w(10'h003, 5'h02, 1'h0));
    check_bit(pump, 1'h0);
    period();
    check_cnt(n, 16'h0014);
    $display("test sleep done");
  endtask
  task automatic t_ce;
    check_bit(oe, 1'h1);
    ce = 1'h0;
    #1;
    check_bit(oe, 1'h0);
    check_bit(rbias, 1'h0);
    tick(10);
    ce = 1'h1;
    tick(10);
    $display("test chip enable done");
  endtask
  task automatic t_pol;
    for (int p = 0; p < 2; p++) begin
      send(ref_w(1'h0, 1'(p), 1'h0, 10'h002));
      tick(400);
      for (int i = 0; i < 2000 && oe !== 1'h1; i++) tick(1);
      if (oe !== 1'h1) timeout();
      check_bit(oe, 1'h1);
      check_bit(pump, 1'(p));
    end
    send(ref_w(1'h0, 1'h1, 1'h1, 10'h002));
    tick(50);
    check_bit(oe, 1'h0);
    $display("test polarity done");
  endtask
  initial begin
    tick(3);
    rst = 1'h0;
    // The bias needs two edges through the synchroniser and one to register.
    tick(3);
    t_reset();
    t_test();
    t_sleep();
    t_ce();
    t_pol();
    print_verdict();
  end
endmodule // tb_pss_core
`default_nettype wire
